// ==== include/isgc_pkg.sv ====
`default_nettype none

package isgc_pkg;

    // Core clock rate and the wake-up delay of the SPI isolator channels
    localparam int unsigned CLK_FREQ_KHZ = 40000;
    localparam int unsigned WAKE_NS      = 100;
    localparam int unsigned WAKE_CNT_W   = 3;
    // Least time, so round up to whole cycles
    localparam int unsigned WAKE_CYC_I   = (WAKE_NS * CLK_FREQ_KHZ + 999999) / 1000000;
    localparam logic [WAKE_CNT_W-1:0] WAKE_CYC = WAKE_CNT_W'(WAKE_CYC_I);

    // Peak sampling uncertainty allowed on the general-purpose channels
    localparam int unsigned GP_JITTER_NS = 10000;
    // One full exchange per half of that budget leaves margin for the crossings
    localparam int unsigned GP_PERIOD_NS = GP_JITTER_NS / 2;
    localparam int unsigned GP_CNT_W     = 8;
    // Longest time, so round down
    localparam int unsigned GP_PERIOD_CYC_I = (GP_PERIOD_NS * CLK_FREQ_KHZ) / 1000000;
    localparam logic [GP_CNT_W-1:0] GP_PERIOD_CYC = GP_CNT_W'(GP_PERIOD_CYC_I - 1);

    // Reset values
    localparam logic [WAKE_CNT_W-1:0] WAKE_CNT_RST = 3'h0;
    localparam logic [GP_CNT_W-1:0]   GP_CNT_RST   = 8'h00;

endpackage : isgc_pkg

`default_nettype wire

// ==== rtl/isgc_top.sv ====
`timescale 1ns/1ps
`default_nettype none

// Operation
// - With select low the target clock follows the controller clock, target data-in follows controller data-out, and controller data-in follows target data-out.
// - With select high the target clock, target data-in and controller data-in outputs are not driven.
// - The select line is passed to the target side with the same level in both states.
// - The clock and data channels wake only after select falls, and go back to sleep on the third core clock edge after select rises.
// - After select falls, no clock or data edge reaches the target side before 100 ns of wake-up time.
// - Clock and data edges pass without any clocking, so every SPI mode works.
// - All general-purpose inputs of one side are sampled together and sent as one packet.
// - After one side's packet is delivered, the other side's inputs are sampled and sent back, alternating while both sides are powered.
// - The exchange repeats fast enough that outputs follow inputs within about 10 us.
// - Outputs follow the far side's inputs with both sides powered, and stay low while either side has not yet powered up.
// - If one side loses power, its outputs go low while the powered side's outputs hold.
module isgc_top
    import isgc_pkg::*;
#(
    parameter int unsigned GP_CHANNELS = 3
) (
    input  wire logic                   i_clk,
    input  wire logic                   i_arst_n,
    input  wire logic                   i_link_clk,
    // SPI pass-through, controller side
    input  wire logic                   i_ctrl_side_clk_in,
    input  wire logic                   i_ctrl_side_dout_in,
    input  wire logic                   i_ctrl_side_select_n,
    output logic                        o_ctrl_side_din_out,
    output logic                        o_ctrl_side_din_oe,
    // SPI pass-through, target side
    input  wire logic                   i_tgt_side_dout_in,
    output logic                        o_tgt_side_clk_out,
    output logic                        o_tgt_side_clk_oe,
    output logic                        o_tgt_side_din_out,
    output logic                        o_tgt_side_din_oe,
    output logic                        o_tgt_side_select_n,
    output logic                        o_spi_chan_active,
    // Supplies, as level flags
    input  wire logic                   i_ctrl_side_supply,
    input  wire logic                   i_tgt_side_supply,
    // General-purpose channels
    input  wire logic [GP_CHANNELS-1:0] i_ctrl_side_gp_input,
    input  wire logic [GP_CHANNELS-1:0] i_tgt_side_gp_input,
    output logic      [GP_CHANNELS-1:0] o_ctrl_side_gp_output,
    output logic      [GP_CHANNELS-1:0] o_tgt_side_gp_output
);

    localparam int unsigned N = GP_CHANNELS;

    // State of the core (controller-side) domain
    typedef struct packed {
        logic                  sel_s1;
        logic                  sel_s2;
        logic [WAKE_CNT_W-1:0] wake_cnt;
        logic                  spi_active;
        logic [N-1:0]          cgp_s1;
        logic [N-1:0]          cgp_s2;
        logic                  cpwr_s1;
        logic                  cpwr_s2;
        logic                  tpwr_s1;
        logic                  tpwr_s2;
        logic [GP_CNT_W-1:0]   per_cnt;
        logic                  req_tgl;
        logic [N-1:0]          req_data;
        logic                  busy;
        logic                  ack_s1;
        logic                  ack_s2;
        logic                  ack_s3;
        logic                  ret_pend;
        logic [N-1:0]          ret_data;
        logic [1:0][N-1:0]     fifo_mem;
        logic                  fifo_wp;
        logic                  fifo_rp;
        logic [1:0]            fifo_cnt;
        logic [N-1:0]          gp_out;
    } isgc_ctrl_state_t;

    // State of the link (target-side) domain
    typedef struct packed {
        logic         req_s1;
        logic         req_s2;
        logic         req_s3;
        logic [N-1:0] tgp_s1;
        logic [N-1:0] tgp_s2;
        logic         tpwr_s1;
        logic         tpwr_s2;
        logic         ack_tgl;
        logic [N-1:0] ack_data;
        logic [N-1:0] gp_out;
    } isgc_link_state_t;

    localparam isgc_ctrl_state_t CTRL_RST = '{
        sel_s1:     1'h1,
        sel_s2:     1'h1,
        wake_cnt:   WAKE_CNT_RST,
        per_cnt:    GP_CNT_RST,
        default:    '0
    };

    localparam isgc_link_state_t LINK_RST = '{
        default:    '0
    };

    isgc_ctrl_state_t c_reg;
    isgc_ctrl_state_t c_next;
    isgc_link_state_t l_reg;
    isgc_link_state_t l_next;

    // Buffer and crossing handshake terms, core domain except req_edge
    logic fifo_in_valid;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic ack_edge;
    logic launch;
    logic req_edge;

    // SPI paths are pure gates: no clock touches them, so the CPOL/CPHA mode is free
    assign o_tgt_side_select_n = i_ctrl_side_select_n;
    assign o_tgt_side_clk_out  = i_ctrl_side_clk_in;
    assign o_tgt_side_din_out  = i_ctrl_side_dout_in;
    assign o_ctrl_side_din_out = i_tgt_side_dout_in;

    // Enables drop at once on a raised select; the wake flag only gates the rising side
    assign o_tgt_side_clk_oe  = c_reg.spi_active & ~i_ctrl_side_select_n;
    assign o_tgt_side_din_oe  = c_reg.spi_active & ~i_ctrl_side_select_n;
    assign o_ctrl_side_din_oe = c_reg.spi_active & ~i_ctrl_side_select_n;
    assign o_spi_chan_active  = c_reg.spi_active;

    assign o_ctrl_side_gp_output = c_reg.gp_out;
    assign o_tgt_side_gp_output  = l_reg.gp_out;

    // Buffer sides: returned packets fill it, the controller-side outputs drain it
    assign fifo_in_valid  = c_reg.ret_pend;
    assign fifo_in_ready  = (c_reg.fifo_cnt != 2'h2);
    assign fifo_out_valid = (c_reg.fifo_cnt != 2'h0);
    assign fifo_out_ready = c_reg.cpwr_s2;
    assign ack_edge       = c_reg.ack_s2 ^ c_reg.ack_s3;
    assign req_edge       = l_reg.req_s2 ^ l_reg.req_s3;

    // A new exchange only starts once the previous return has left for the buffer
    assign launch = (c_reg.per_cnt == GP_CNT_RST) & ~c_reg.busy & ~c_reg.ret_pend
                  & c_reg.cpwr_s2 & c_reg.tpwr_s2;

    // Core domain next state
    always_comb begin
        c_next = c_reg;

        // Two-stage synchronisers for pins and link-domain signals
        c_next.sel_s1  = i_ctrl_side_select_n;
        c_next.sel_s2  = c_reg.sel_s1;
        c_next.cgp_s1  = i_ctrl_side_gp_input;
        c_next.cgp_s2  = c_reg.cgp_s1;
        c_next.cpwr_s1 = i_ctrl_side_supply;
        c_next.cpwr_s2 = c_reg.cpwr_s1;
        c_next.tpwr_s1 = i_tgt_side_supply;
        c_next.tpwr_s2 = c_reg.tpwr_s1;
        c_next.ack_s1  = l_reg.ack_tgl;
        c_next.ack_s2  = c_reg.ack_s1;
        c_next.ack_s3  = c_reg.ack_s2;

        // Wake-up: the channels stay asleep until select has been low long enough.
        // The synchroniser adds two cycles on top, which only lengthens the wait.
        if (c_reg.sel_s2) begin
            c_next.wake_cnt   = WAKE_CNT_RST;
            c_next.spi_active = 1'b0;
        end else if (c_reg.wake_cnt != WAKE_CYC) begin
            c_next.wake_cnt = c_reg.wake_cnt + 3'h1;
        end else begin
            c_next.spi_active = 1'b1;
        end

        // Exchange period counter
        if (c_reg.per_cnt != GP_CNT_RST) begin
            c_next.per_cnt = c_reg.per_cnt - 8'h01;
        end else if (launch) begin
            c_next.per_cnt = GP_PERIOD_CYC;
        end

        // Outbound packet: all inputs snapped in one cycle, held until acknowledged
        if (launch) begin
            c_next.req_data = c_reg.cgp_s2;
            c_next.req_tgl  = ~c_reg.req_tgl;
            c_next.busy     = 1'b1;
        end

        // Returned packet from the far side
        if (c_reg.busy && ack_edge) begin
            c_next.busy     = 1'b0;
            c_next.ret_pend = 1'b1;
            c_next.ret_data = l_reg.ack_data;
        end else if (fifo_in_valid && fifo_in_ready) begin
            c_next.ret_pend = 1'b0;
        end

        // Two-entry buffer; a full buffer holds ret_pend and so stalls new launches
        if (fifo_in_valid && fifo_in_ready) begin
            c_next.fifo_mem[c_reg.fifo_wp] = c_reg.ret_data;
            c_next.fifo_wp = ~c_reg.fifo_wp;
        end
        if (fifo_out_valid && fifo_out_ready) begin
            c_next.fifo_rp = ~c_reg.fifo_rp;
        end
        c_next.fifo_cnt = c_reg.fifo_cnt
                        + {1'b0, fifo_in_valid & fifo_in_ready}
                        - {1'b0, fifo_out_valid & fifo_out_ready};

        // Controller-side outputs: whole word at once, low without own supply.
        // Losing only the far supply stops the exchange, so these simply hold.
        if (!c_reg.cpwr_s2) begin
            c_next.gp_out = '0;
        end else if (fifo_out_valid) begin
            c_next.gp_out = c_reg.fifo_mem[c_reg.fifo_rp];
        end
    end

    // Core domain register
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            c_reg <= CTRL_RST;
        end else begin
            c_reg <= c_next;
        end
    end

    // Link domain next state
    always_comb begin
        l_next = l_reg;

        l_next.req_s1  = c_reg.req_tgl;
        l_next.req_s2  = l_reg.req_s1;
        // A request that arrives while this side is unpowered stays pending, so
        // the core is never left waiting for an answer that was dropped
        if (l_reg.tpwr_s2) begin
            l_next.req_s3 = l_reg.req_s2;
        end
        l_next.tgp_s1  = i_tgt_side_gp_input;
        l_next.tgp_s2  = l_reg.tgp_s1;
        l_next.tpwr_s1 = i_tgt_side_supply;
        l_next.tpwr_s2 = l_reg.tpwr_s1;

        // Request data is held stable by the core until the toggle is answered
        if (!l_reg.tpwr_s2) begin
            l_next.gp_out = '0;
        end else if (req_edge) begin
            l_next.gp_out   = c_reg.req_data;
            // Turn the coil round: sample this side and answer with it
            l_next.ack_data = l_reg.tgp_s2;
            l_next.ack_tgl  = ~l_reg.ack_tgl;
        end
    end

    // Link domain register
    always_ff @(posedge i_link_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            l_reg <= LINK_RST;
        end else begin
            l_reg <= l_next;
        end
    end

endmodule : isgc_top

`default_nettype wire

// ==== verification/isgc_peer.sv ====
`timescale 1ns/1ps
`default_nettype none
// Target peripheral: each rising clock edge answers with the inverse of the bit taken
module isgc_peer (
    input  wire logic i_sck,
    input  wire logic i_sdi,
    input  wire logic i_sel_n,
    output logic      o_sdo
);
    logic sdo_reg = 1'h0;
    assign o_sdo = sdo_reg;
    // Deselect flips the line so a stale bit never passes for a fresh one
    always @(posedge i_sck or posedge i_sel_n) begin
        sdo_reg <= i_sel_n ? ~sdo_reg : ~i_sdi;
    end
endmodule : isgc_peer
`default_nettype wire

// ==== verification/isgc_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module isgc_chk #(
    parameter int unsigned GP_CHANNELS = 3
) (
    input wire logic                   i_clk,
    input wire logic                   i_arst_n,
    input wire logic                   i_ctrl_side_clk_in,
    input wire logic                   i_ctrl_side_select_n,
    input wire logic                   o_ctrl_side_din_oe,
    input wire logic                   o_tgt_side_clk_out,
    input wire logic                   o_tgt_side_clk_oe,
    input wire logic                   o_tgt_side_select_n,
    input wire logic                   o_spi_chan_active,
    input wire logic                   i_ctrl_side_supply,
    input wire logic                   i_tgt_side_supply,
    input wire logic [GP_CHANNELS-1:0] o_ctrl_side_gp_output
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);
    // Wake-up steps; a long enough low select must have woken the drivers
    sequence sel_fall; $fell(i_ctrl_side_select_n); endsequence
    sequence sel_low8; !i_ctrl_side_select_n [*8]; endsequence
    sel_relay_a: assert property (o_tgt_side_select_n == i_ctrl_side_select_n)
        else $error("select not relayed");
    idle_float_a: assert property (i_ctrl_side_select_n |-> !o_tgt_side_clk_oe &&
        !o_ctrl_side_din_oe) else $error("pins driven while deselected");
    clk_pass_a: assert property (o_tgt_side_clk_oe |->
        o_tgt_side_clk_out == i_ctrl_side_clk_in) else $error("clock not passed");
    wake_hold_a: assert property (sel_fall |-> !o_tgt_side_clk_oe [*4])
        else $error("drivers woke too early");
    wake_bound_a: assert property (sel_fall ##1 sel_low8 |=>
        o_tgt_side_clk_oe || i_ctrl_side_select_n) else $error("drivers never woke");
    sleep_entry_a: assert property (i_ctrl_side_select_n [*5] |-> !o_spi_chan_active)
        else $error("channels stay awake");
    ctrl_low_a: assert property (!i_ctrl_side_supply [*5] |->
        o_ctrl_side_gp_output == '0) else $error("unpowered outputs not low");
    ctrl_hold_a: assert property (!i_tgt_side_supply [*8] ##2 !i_tgt_side_supply |->
        $stable(o_ctrl_side_gp_output) || !i_ctrl_side_supply) else $error("outputs not held");
endmodule : isgc_chk
bind isgc_top isgc_chk #(.GP_CHANNELS(GP_CHANNELS)) u_chk (.*);
`default_nettype wire

// ==== verification/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic       clk = 1'h0, lclk = 1'h0, arst_n = 1'h0, sck = 1'h0, mosi = 1'h0, sel_n = 1'h1;
    logic       sup_c = 1'h1, sup_t = 1'h0, tgt_dout, din_out, din_oe, sck_out, sck_oe;
    logic       sdi_out, sdi_oe, sel_out, active;
    logic [2:0] gpi_c = 3'h5, gpi_t = 3'h6, gpo_c, gpo_t;
    logic [7:0] lfsr = 8'h13;
    int         mismatches = 0, checks = 0, exp_c = 0, exp_t = 0;
    // Floating target pins read low through their pull-downs
    wire logic  sck_w = sck_oe & sck_out;
    wire logic  sdi_w = sdi_oe & sdi_out;
    isgc_top uut (.i_clk(clk), .i_arst_n(arst_n), .i_link_clk(lclk), .i_ctrl_side_clk_in(sck),
        .i_ctrl_side_dout_in(mosi), .i_ctrl_side_select_n(sel_n), .o_ctrl_side_din_out(din_out),
        .o_ctrl_side_din_oe(din_oe), .i_tgt_side_dout_in(tgt_dout), .o_tgt_side_clk_out(sck_out),
        .o_tgt_side_clk_oe(sck_oe), .o_tgt_side_din_out(sdi_out), .o_tgt_side_din_oe(sdi_oe),
        .o_tgt_side_select_n(sel_out), .o_spi_chan_active(active), .i_ctrl_side_supply(sup_c),
        .i_tgt_side_supply(sup_t), .i_ctrl_side_gp_input(gpi_c), .i_tgt_side_gp_input(gpi_t),
        .o_ctrl_side_gp_output(gpo_c), .o_tgt_side_gp_output(gpo_t));
    isgc_peer u_peer (.i_sck(sck_w), .i_sdi(sdi_w), .i_sel_n(sel_out), .o_sdo(tgt_dout));
    // Core clock 25 ns; link clock 30 ns with its own phase
    initial begin
        forever #12.5 clk = ~clk;
    end
    initial begin
        #7.3 forever #15 lclk = ~lclk;
    end
    function automatic logic [7:0] lfsr_next(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction : lfsr_next
    // Inputs always move 2 ns after the edge, clear of sampling
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask : tick
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_of_test
    // Whole run is near 3500 cycles, so this only trips on a hang
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        end_of_test();
    end
    // Startup with the target unpowered, one SPI frame, then supply steps
    initial begin
        tick(20);
        arst_n = 1'h1;
        tick(300);
        check({gpo_c, gpo_t}, 8'h00);
        sel_n = 1'h0;
        tick(9);
        check({active, sck_oe, sdi_oe, din_oe}, 8'h0F);
        for (int i = 0; i < 16; i++) begin
            lfsr = lfsr_next(lfsr);
            {sck, mosi} = lfsr[1:0];
            #1 check({sck_w, sdi_w, din_out}, {lfsr[1:0], tgt_dout});
            tick(1);
        end
        {sck, sel_n} = 2'h1;
        #1 check({sel_out, sck_oe, sdi_oe, din_oe}, 8'h08);
        tick(1);
        // Supply table per step: both for four steps, target lost, both, controller lost, both
        for (int s = 0; s < 8; s++) begin
            {sup_c, sup_t} = 2'(16'hDEFF >> (2 * s));
            tick(4);
            lfsr = lfsr_next(lfsr);
            {gpi_c, gpi_t} = lfsr[5:0];
            exp_c = !sup_c ? 0 : sup_t ? gpi_t : exp_c;
            exp_t = !sup_t ? 0 : sup_c ? gpi_c : exp_t;
            tick(400);
            check({gpo_c, gpo_t}, 8'(exp_c * 8 + exp_t));
        end
        end_of_test();
    end
endmodule : testbench
`default_nettype wire
